// ==== rtl/bre_regs.svh ====
// Purpose: Register offsets, field positions, reset values and widths of the ECC block RAM
// Assumes: AXI4-Lite byte addresses, one aligned 32-bit word per register
// Notes:   Definitions only
`ifndef BRE_REGS_SVH
`define BRE_REGS_SVH

// Word widths
`define BRE_DATA_W        64
`define BRE_CHECK_W       8
`define BRE_WORD_W        72
`define BRE_HAM_W         7
`define BRE_MAX_POS       7'h47

// Register byte offsets
`define BRE_OFF_CTRL      8'h00
`define BRE_OFF_STATUS    8'h04
`define BRE_OFF_MASK      8'h08
`define BRE_OFF_CHECK     8'h0C
`define BRE_OFF_COUNT     8'h10

// Control fields
`define BRE_CTRL_ENC_BIT  0
`define BRE_CTRL_DEC_BIT  1
`define BRE_CTRL_OREG_BIT 2
`define BRE_CTRL_RST      3'h3

// Status and mask fields
`define BRE_ST_SBE_BIT    0
`define BRE_ST_DBE_BIT    1
`define BRE_ST_RST        2'h0
`define BRE_MASK_RST      2'h0

// Bus answers
`define BRE_RESP_OKAY     2'h0
`define BRE_RESP_SLVERR   2'h2

`endif

// ==== rtl/bre_pkg.sv ====
// Purpose: Types shared by the ECC block RAM
// Assumes: bre_regs.svh holds the numbers
// Notes:   Types only
`include "bre_regs.svh"

package bre_pkg;

  typedef logic [`BRE_WORD_W-1:0] bre_word_t;

  typedef struct packed {
    logic oreg;
    logic dec_en;
    logic enc_en;
  } bre_mode_s;

  typedef struct packed {
    logic [`BRE_DATA_W-1:0]  data;
    logic [`BRE_CHECK_W-1:0] check;
    logic                    sbe;
    logic                    dbe;
  } bre_rd_s;

endpackage : bre_pkg

// ==== rtl/bre_top.sv ====
// Purpose: 72-bit block memory with SECDED encode and decode, AXI4-Lite control
// Assumes: write port, read port and bus all run on aclk
// Notes:   Memory contents are not reset
//
// What this block does
// - Decoder on: a word with one flipped bit reads back corrected, single flag set.
// - Decoder on: a word with two flipped bits reads back unchanged, double flag set.
// - Encoder on: every 64-bit write forms eight check bits internally.
// - Encoder on: fresh check value appears on the check output right after the write.
// - After an encoded write the whole 72-bit word reads back.
// - Check output is a register of the write-side clock.
// - Single error flag is clocked by read side, with or without output register.
// - Double error flag is clocked by read side, with or without output register.
// - Encode-only reads are plain reads: no correction, flags never set.
// - Each error flag appears in the same cycle as its data word.
`timescale 1ns/1ns
`include "bre_regs.svh"

module bre_top #(
  parameter int ADDR_W = 9,
  parameter int AXI_AW = 8
) (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite write address
  input  wire logic [AXI_AW-1:0]       s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [AXI_AW-1:0]       s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Interrupt
  output logic                         irq,
  // Memory write port
  input  wire logic                    wr_en,
  input  wire logic [ADDR_W-1:0]       wr_addr,
  input  wire logic [`BRE_DATA_W-1:0]  write_data_in,
  input  wire logic [`BRE_CHECK_W-1:0] write_check_in,
  output logic [`BRE_CHECK_W-1:0]      generated_check_bits,
  // Memory read port
  input  wire logic                    rd_en,
  input  wire logic [ADDR_W-1:0]       rd_addr,
  output logic [`BRE_DATA_W-1:0]       read_data_out,
  output logic [`BRE_CHECK_W-1:0]      read_check_out,
  output logic                         single_error_flag,
  output logic                         double_error_flag,
  output logic                         read_valid
);

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (ADDR_W < 1 || ADDR_W > 16) begin : g_chk_addr
    $error("bre_top: ADDR_W must lie in 1..16");
  end
  if (AXI_AW < 8 || AXI_AW > 32) begin : g_chk_axi
    $error("bre_top: AXI_AW must lie in 8..32");
  end

  localparam int DEPTH = 1 << ADDR_W;

  ////////////////////////////////////////////////////////////////////////////////
  // Code functions

  // Codeword position of data bit j: the j-th position that is no power of two
  function automatic logic [`BRE_HAM_W-1:0] bre_pos(input int j);
    int r;
    int c;
    r = 0;
    c = 0;
    for (int p = 1; p <= 71; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (c == j) begin
          r = p;
        end
        c++;
      end
    end
    return r[`BRE_HAM_W-1:0];
  endfunction : bre_pos

  // Extended Hamming check byte
  function automatic logic [`BRE_CHECK_W-1:0] bre_encode(input logic [`BRE_DATA_W-1:0] d);
    logic [`BRE_CHECK_W-1:0] c;
    logic [`BRE_HAM_W-1:0]   p;
    c = '0;
    for (int j = 0; j < `BRE_DATA_W; j++) begin
      p = bre_pos(j);
      for (int k = 0; k < `BRE_HAM_W; k++) begin
        if (p[k]) begin
          c[k] = c[k] ^ d[j];
        end
      end
    end
    c[`BRE_CHECK_W-1] = (^d) ^ (^c[`BRE_HAM_W-1:0]);
    return c;
  endfunction : bre_encode

  // Syndrome decode with single correction and double detection
  function automatic bre_pkg::bre_rd_s bre_decode(input bre_pkg::bre_word_t w);
    bre_pkg::bre_rd_s        r;
    logic [`BRE_CHECK_W-1:0] re;
    logic [`BRE_HAM_W-1:0]   syn;
    logic                    par;
    logic                    fix;
    r.data  = w[`BRE_DATA_W-1:0];
    r.check = w[`BRE_WORD_W-1:`BRE_DATA_W];
    re      = bre_encode(r.data);
    syn     = re[`BRE_HAM_W-1:0] ^ r.check[`BRE_HAM_W-1:0];
    par     = ^w;
    fix     = par && (syn <= `BRE_MAX_POS);
    r.sbe   = fix;
    r.dbe   = (!par && (syn != 7'h00)) || (par && (syn > `BRE_MAX_POS));
    if (fix) begin
      for (int j = 0; j < `BRE_DATA_W; j++) begin
        if (bre_pos(j) == syn) begin
          r.data[j] = ~r.data[j];
        end
      end
      for (int k = 0; k < `BRE_HAM_W; k++) begin
        if (syn == (7'h01 << k)) begin
          r.check[k] = ~r.check[k];
        end
      end
      if (syn == 7'h00) begin
        r.check[`BRE_CHECK_W-1] = ~r.check[`BRE_CHECK_W-1];
      end
    end
    return r;
  endfunction : bre_decode

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers
  bre_pkg::bre_mode_s      mode_q;
  logic [1:0]              status_q;
  logic [1:0]              mask_q;
  logic [15:0]             sbe_cnt_q;
  logic [15:0]             dbe_cnt_q;
  logic [`BRE_CHECK_W-1:0] gen_check_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Memory and write port
  bre_pkg::bre_word_t      mem_q [DEPTH];
  logic [`BRE_CHECK_W-1:0] enc_check;
  logic [`BRE_CHECK_W-1:0] store_check;

  assign enc_check   = bre_encode(write_data_in);
  assign store_check = mode_q.enc_en ? enc_check : write_check_in;

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= {store_check, write_data_in};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_check_q <= 8'h00;
    end else if (wr_en && mode_q.enc_en) begin
      gen_check_q <= enc_check;
    end
  end

  assign generated_check_bits = gen_check_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Read pipeline
  bre_pkg::bre_word_t rd_raw;
  bre_pkg::bre_rd_s   rd_plain;
  bre_pkg::bre_rd_s   rd_dec;
  bre_pkg::bre_rd_s   s1_q;
  bre_pkg::bre_rd_s   s2_q;
  bre_pkg::bre_rd_s   rd_out;
  logic               s1_v_q;
  logic               s2_v_q;
  logic               out_v;

  assign rd_raw   = mem_q[rd_addr];
  assign rd_plain = '{data: rd_raw[`BRE_DATA_W-1:0],
                      check: rd_raw[`BRE_WORD_W-1:`BRE_DATA_W],
                      sbe: 1'b0, dbe: 1'b0};
  assign rd_dec   = mode_q.dec_en ? bre_decode(rd_raw) : rd_plain;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q   <= '0;
      s1_v_q <= 1'b0;
    end else begin
      s1_v_q <= rd_en;
      if (rd_en) begin
        s1_q <= rd_dec;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s2_q   <= '0;
      s2_v_q <= 1'b0;
    end else begin
      s2_v_q <= s1_v_q;
      s2_q   <= s1_q;
    end
  end

  assign rd_out            = mode_q.oreg ? s2_q : s1_q;
  assign out_v             = mode_q.oreg ? s2_v_q : s1_v_q;
  assign read_data_out     = rd_out.data;
  assign read_check_out    = rd_out.check;
  assign single_error_flag = rd_out.sbe;
  assign double_error_flag = rd_out.dbe;
  assign read_valid        = out_v;

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  logic              aw_have_q;
  logic [7:0]        aw_addr_q;
  logic              w_have_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              do_write;
  logic              wr_hit;
  logic              wr_ctrl;
  logic              wr_status;
  logic              wr_mask;
  logic [1:0]        st_clr;

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;
  assign do_write      = aw_have_q && w_have_q && !bvalid_q;
  assign wr_ctrl       = do_write && (aw_addr_q == `BRE_OFF_CTRL) && w_strb_q[0];
  assign wr_status     = do_write && (aw_addr_q == `BRE_OFF_STATUS) && w_strb_q[0];
  assign wr_mask       = do_write && (aw_addr_q == `BRE_OFF_MASK) && w_strb_q[0];
  assign wr_hit        = (aw_addr_q == `BRE_OFF_CTRL) || (aw_addr_q == `BRE_OFF_STATUS) ||
                         (aw_addr_q == `BRE_OFF_MASK) || (aw_addr_q == `BRE_OFF_CHECK) ||
                         (aw_addr_q == `BRE_OFF_COUNT);
  assign st_clr        = wr_status ? w_data_q[1:0] : 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `BRE_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? `BRE_RESP_OKAY : `BRE_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode, status, mask and counters
  logic [1:0] ev;

  assign ev = out_v ? {rd_out.dbe, rd_out.sbe} : 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= `BRE_CTRL_RST;
      mask_q <= `BRE_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        mode_q.enc_en <= w_data_q[`BRE_CTRL_ENC_BIT];
        mode_q.dec_en <= w_data_q[`BRE_CTRL_DEC_BIT];
        mode_q.oreg   <= w_data_q[`BRE_CTRL_OREG_BIT];
      end
      if (wr_mask) begin
        mask_q <= w_data_q[1:0];
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= `BRE_ST_RST;
    end else begin
      status_q <= (status_q & ~st_clr) | ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sbe_cnt_q <= 16'h0000;
      dbe_cnt_q <= 16'h0000;
    end else begin
      if (ev[`BRE_ST_SBE_BIT] && (sbe_cnt_q != 16'hFFFF)) begin
        sbe_cnt_q <= sbe_cnt_q + 16'h0001;
      end
      if (ev[`BRE_ST_DBE_BIT] && (dbe_cnt_q != 16'hFFFF)) begin
        dbe_cnt_q <= dbe_cnt_q + 16'h0001;
      end
    end
  end

  assign irq = |(status_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  logic [7:0]  ar_addr;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  assign s_axi_arready = !rvalid_q;
  assign ar_addr       = {s_axi_araddr[7:2], 2'h0};
  assign rd_hit        = (ar_addr == `BRE_OFF_CTRL) || (ar_addr == `BRE_OFF_STATUS) ||
                         (ar_addr == `BRE_OFF_MASK) || (ar_addr == `BRE_OFF_CHECK) ||
                         (ar_addr == `BRE_OFF_COUNT);
  assign rd_mux        = (ar_addr == `BRE_OFF_CTRL)   ? {29'h0, mode_q} :
                         (ar_addr == `BRE_OFF_STATUS) ? {30'h0, status_q} :
                         (ar_addr == `BRE_OFF_MASK)   ? {30'h0, mask_q} :
                         (ar_addr == `BRE_OFF_CHECK)  ? {24'h0, gen_check_q} :
                         (ar_addr == `BRE_OFF_COUNT)  ? {dbe_cnt_q, sbe_cnt_q} :
                         32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `BRE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? `BRE_RESP_OKAY : `BRE_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule : bre_top

// ==== tb/bre_chk.sv ====
// Purpose: Port-level assertions of the ECC block memory
// Assumes: one clock, synchronous active-low reset
// Notes:   Bound to bre_top below the module
`timescale 1ns/1ns
`include "bre_regs.svh"
module bre_chk (
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // Memory ports
  input wire logic                    wr_en,
  input wire logic                    rd_en,
  input wire logic [`BRE_CHECK_W-1:0] generated_check_bits,
  input wire logic                    single_error_flag,
  input wire logic                    double_error_flag,
  input wire logic                    read_valid,
  // Bus answers
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic [31:0]             s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_rv_cause; read_valid |-> $past(rd_en) || $past(rd_en, 2); endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("read word without request");
  property p_rv_bound; rd_en |-> ##[1:2] read_valid; endproperty
  a_rv_bound: assert property (p_rv_bound) else $error("read word missing");
  property p_sbe_rise; $rose(single_error_flag) |-> read_valid; endproperty
  a_sbe_rise: assert property (p_sbe_rise) else $error("single flag off its word");
  property p_dbe_rise; $rose(double_error_flag) |-> read_valid; endproperty
  a_dbe_rise: assert property (p_dbe_rise) else $error("double flag off its word");
  property p_excl; !(single_error_flag && double_error_flag); endproperty
  a_excl: assert property (p_excl) else $error("both error flags high");
  property p_gen; $changed(generated_check_bits) |-> $past(wr_en); endproperty
  a_gen: assert property (p_gen) else $error("check output moved without write");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  ////////////////////////////////////////////////////////////////////////////////
  c_sbe: cover property (read_valid && single_error_flag);
  c_dbe: cover property (read_valid && double_error_flag);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : bre_chk

bind bre_top bre_chk u_chk (.aclk, .aresetn, .wr_en, .rd_en, .generated_check_bits,
  .single_error_flag, .double_error_flag, .read_valid, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// ==== tb/bre_fab.sv ====
// Purpose: Fabric logic driving the memory write and read ports
// Assumes: one register stage between a bench command and the ports
// Notes:   Idle data and address lines show the inverse of their last value
`timescale 1ns/1ns
module bre_fab (
  // Clock
  input  wire logic        aclk,
  // Bench commands
  input  wire logic        cmd_v,
  input  wire logic        cmd_wr,
  input  wire logic [8:0]  cmd_addr,
  input  wire logic [63:0] cmd_data,
  input  wire logic [7:0]  cmd_chk,
  // Memory ports, plain memory only, no buffer shares them
  output logic             wr_en,
  output logic [8:0]       wr_addr,
  output logic [63:0]      write_data_in,
  output logic [7:0]       write_check_in,
  output logic             rd_en,
  output logic [8:0]       rd_addr
);
  wire logic do_wr = cmd_v & cmd_wr;
  wire logic do_rd = cmd_v & ~cmd_wr;
  initial begin
    {wr_en, rd_en, wr_addr, rd_addr, write_data_in, write_check_in} = '0;
  end
  always @(posedge aclk) begin
    wr_en          <= do_wr;
    rd_en          <= do_rd;
    wr_addr        <= do_wr ? cmd_addr : ~wr_addr;
    write_data_in  <= do_wr ? cmd_data : ~write_data_in;
    write_check_in <= do_wr ? cmd_chk : ~write_check_in;
    rd_addr        <= do_rd ? cmd_addr : ~rd_addr;
  end
endmodule : bre_fab

// ==== tb/test_block_ram_secded_ecc.sv ====
// Purpose: Self-checking bench of the ECC block memory
// Assumes: bre_fab turns each command into a port access one cycle later
// Notes:   Random words come from a bench LFSR
`timescale 1ns/1ns
`include "bre_regs.svh"
module test_block_ram_secded_ecc;
  logic        aclk = 1'h0, aresetn = 1'h0, cmd_v = 1'h0, cmd_wr = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, cmd_chk = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rnd = 32'h8ADC431C, r;
  wire  [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  wire  [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        irq, wr_en, rd_en, single_error_flag, double_error_flag, read_valid;
  logic [8:0]  wr_addr, rd_addr, cmd_addr = 9'h000;
  logic [63:0] write_data_in, read_data_out, cmd_data = 64'h0, d;
  logic [7:0]  write_check_in, generated_check_bits, read_check_out;
  logic [71:0] w, e, ws, es;
  int          err_count = 0, num_checks = 0, p1, p2;

  bre_top dut (.*);
  bre_fab u_fab (.*);
  always #50 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'h0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr

  function automatic logic [7:0] enc(input logic [63:0] v);
    logic [7:0] c;
    int         j;
    c = 8'h00;
    j = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int k = 0; k < 7; k++) c[k] ^= p[k] & v[j];
        j++;
      end
    end
    c[7] = ^{v, c[6:0]};
    return c;
  endfunction : enc

  task automatic chk(input logic [79:0] s, input logic [79:0] x);
    num_checks++;
    if (s !== x) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  task automatic test_done;
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////////
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic pa, pw;
    pa = 1'h1;
    pw = 1'h1;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && s_axi_awready === 1'h1) begin
        pa = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (pw && s_axi_wready === 1'h1) begin
        pw = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    v = s_axi_rdata;
    chk(s_axi_rresp, er);
  endtask : axr

  // Command to fabric, then sample where the word appears
  task automatic mem(input logic wr, input logic [8:0] a, input logic [63:0] v,
                     input logic [7:0] c, input logic o);
    @(posedge aclk);
    cmd_v    <= 1'h1;
    cmd_wr   <= wr;
    cmd_addr <= a;
    cmd_data <= v;
    cmd_chk  <= c;
    @(posedge aclk);
    cmd_v <= 1'h0;
    @(posedge aclk);
    if (o) @(posedge aclk);
    #1;
    if (!wr) chk(read_valid, 1'h1);
  endtask : mem
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    axr(`BRE_OFF_CTRL, `BRE_RESP_OKAY, r);
    chk(r, `BRE_CTRL_RST);
    axr(`BRE_OFF_STATUS, `BRE_RESP_OKAY, r);
    chk({r, generated_check_bits, irq}, {30'h0, `BRE_ST_RST, 9'h000});
    axr(`BRE_OFF_MASK, `BRE_RESP_OKAY, r);
    chk(r, `BRE_MASK_RST);
    axr(8'h40, `BRE_RESP_SLVERR, r);
    axw(8'h40, 32'h7, `BRE_RESP_SLVERR);
    axw(`BRE_OFF_CTRL, 32'h1, `BRE_RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 64'h0 : (i == 1) ? '1 : {rnd, lfsr(rnd)};
      rnd = lfsr(lfsr(rnd));
      mem(1'h1, 9'(i), d, 8'h5A, 1'h0);
      chk(generated_check_bits, enc(d));
      axr(`BRE_OFF_CHECK, `BRE_RESP_OKAY, r);
      chk(r, enc(d));
      mem(1'h0, 9'(i), 64'h0, 8'h00, 1'h0);
      chk({read_data_out, read_check_out, single_error_flag, double_error_flag},
          {d, enc(d), 2'h0});
    end
    for (int o = 0; o < 2; o++) begin
      axw(`BRE_OFF_CTRL, 32'(2 + 4 * o), `BRE_RESP_OKAY);
      for (int n = 2; n >= 0; n--) begin
        d = {rnd, lfsr(rnd)};
        rnd = lfsr(lfsr(rnd));
        p1 = rnd % 72;
        p2 = (p1 + 1 + rnd[15:0] % 71) % 72;
        e = {d, enc(d)};
        w = e;
        if (n > 0) w[p1] = ~w[p1];
        if (n > 1) w[p2] = ~w[p2];
        if (n == 1) begin
          ws = w;
          es = e;
        end
        mem(1'h1, 9'(8 + n), w[71:8], w[7:0], 1'(o));
        mem(1'h0, 9'(8 + n), 64'h0, 8'h00, 1'(o));
        chk({read_data_out, read_check_out}, (n == 2) ? w : e);
        chk({single_error_flag, double_error_flag}, {n == 1, n == 2});
      end
    end
    axr(`BRE_OFF_STATUS, `BRE_RESP_OKAY, r);
    chk({r, irq}, {32'h3, 1'h0});
    axr(`BRE_OFF_COUNT, `BRE_RESP_OKAY, r);
    chk(r, 32'h0002_0002);
    axw(`BRE_OFF_MASK, 32'h2, `BRE_RESP_OKAY);
    chk(irq, 1'h1);
    axw(`BRE_OFF_STATUS, 32'h2, `BRE_RESP_OKAY);
    axr(`BRE_OFF_STATUS, `BRE_RESP_OKAY, r);
    chk({r, irq}, {32'h1, 1'h0});
    axw(`BRE_OFF_CTRL, 32'h1, `BRE_RESP_OKAY);
    mem(1'h0, 9'h009, 64'h0, 8'h00, 1'h0);
    chk({read_data_out, read_check_out, single_error_flag, double_error_flag},
        {ws, 2'h0});
    axw(`BRE_OFF_CTRL, 32'h3, `BRE_RESP_OKAY);
    mem(1'h0, 9'h009, 64'h0, 8'h00, 1'h0);
    chk({read_data_out, read_check_out, single_error_flag, double_error_flag},
        {es, 2'h2});
    test_done;
  end

  // Whole run needs well under 1000 cycles
  initial begin
    #(5000 * 100);
    err_count++;
    test_done;
  end
endmodule : test_block_ram_secded_ecc
